// *** core/power_supply_control.sv ***
`timescale 1ns/1ps
`include "power_ctrl_params.svh"
module power_supply_control import power_ctrl_pkg::*; #(
  parameter int CNT_W = 30,
  parameter int T0_CYC = `CROWBAR_T0_MS * (`CLK_KHZ / 1000) * 1000,
  parameter int T1_CYC = `CROWBAR_T1_MS * (`CLK_KHZ / 1000) * 1000,
  parameter int T2_CYC = `CROWBAR_T2_MS * (`CLK_KHZ / 1000) * 1000,
  parameter int T3_CYC = `CROWBAR_T3_MS * (`CLK_KHZ / 1000) * 1000,
  parameter int GAP_CYC = `CROWBAR_GAP_MS * (`CLK_KHZ / 1000) * 1000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire apb_req_type apb_req,
  output apb_rsp_type apb_rsp,
  input wire logic sleep_s3_input,
  input wire logic supply_polarity_strap,
  input wire logic standby_powerup,
  input wire logic standby_fail,
  input wire logic power_good,
  input wire logic [1:0] led_lit,
  output logic supply_on_output,
  output logic [1:0] led_out,
  output logic crowbar_trip
);

  // ==========================================================
  // Configuration state
  // ==========================================================
  logic led_pol_reg;
  logic last_state_reg;
  logic polarity_reg;
  logic [1:0] crowbar_reg;
  logic resume_reg;
  logic acpi_mode_reg;
  logic strap_done_reg;
  logic on_reg;
  logic on_next;
  logic on_prev_reg;
  logic s3_prev_reg;
  logic wr_en;
  logic [7:0] wdata_raw;
  cfg_type wdata;
  cfg_type rdata;
  logic shutoff;
  logic s3_change;
  logic expired;

  assign wdata = cfg_type'(wdata_raw);

  // ==========================================================
  // Bus slave
  // ==========================================================
  apb_cfg_port u_apb (
    .clk(clk),
    .nrst(nrst),
    .req(apb_req),
    .rdata(rdata),
    .rsp(apb_rsp),
    .wr_en(wr_en),
    .wdata(wdata_raw)
  );

  always_comb begin
    rdata = '0;
    rdata.led_pol = led_pol_reg;
    // Failure snapshot is only visible in legacy mode
    rdata.last_state = acpi_mode_reg ? 1'b0 : last_state_reg;
    rdata.polarity = polarity_reg;
    rdata.crowbar = crowbar_reg;
    rdata.resume = resume_reg;
    rdata.supply_off = 1'b0;
    rdata.acpi_mode = acpi_mode_reg;
  end

  // ==========================================================
  // Software-writable fields
  // ==========================================================
  // Standby power-up clears the standby-reset fields; it wins
  // over a write landing on the same edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      led_pol_reg <= `LED_POL_RST;
      acpi_mode_reg <= `ACPI_MODE_RST;
    end else if (standby_powerup) begin
      led_pol_reg <= `LED_POL_RST;
      acpi_mode_reg <= `ACPI_MODE_RST;
    end else if (wr_en) begin
      led_pol_reg <= wdata.led_pol;
      acpi_mode_reg <= wdata.acpi_mode;
    end
  end

  // Battery-backed fields: only the battery reset clears them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crowbar_reg <= `CROWBAR_RST;
      resume_reg <= `RESUME_RST;
    end else if (wr_en) begin
      crowbar_reg <= wdata.crowbar;
      resume_reg <= wdata.resume;
    end
  end

  // ==========================================================
  // Strap and failure snapshot
  // ==========================================================
  // Strap is sampled by a clock edge, never by the reset itself
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      polarity_reg <= `POLARITY_RST;
      strap_done_reg <= 1'b0;
    end else if (standby_powerup || !strap_done_reg) begin
      polarity_reg <= supply_polarity_strap;
      strap_done_reg <= 1'b1;
    end
  end

  // Logical state, so the snapshot ignores output polarity
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_state_reg <= `LAST_STATE_RST;
    end else if (standby_fail) begin
      last_state_reg <= on_reg;
    end
  end

  // ==========================================================
  // Supply-on control
  // ==========================================================
  // Shut-off only acts in legacy mode
  assign shutoff = wr_en && wdata.supply_off && !acpi_mode_reg;
  assign s3_change = sleep_s3_input != s3_prev_reg;

  // Resume mode depends on the chipset coming back off, so
  // the restored state is authoritative until S3 moves.
  always_comb begin
    on_next = on_reg;
    if (standby_powerup) begin
      on_next = resume_reg ? last_state_reg : sleep_s3_input;
    end else if (shutoff) begin
      on_next = 1'b0;
    end else if (expired) begin
      on_next = 1'b0;
    end else if (s3_change) begin
      on_next = sleep_s3_input;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      on_reg <= 1'b0;
      on_prev_reg <= 1'b0;
      s3_prev_reg <= 1'b0;
    end else begin
      on_reg <= on_next;
      on_prev_reg <= on_reg;
      s3_prev_reg <= sleep_s3_input;
    end
  end

  // ==========================================================
  // Crowbar timeout
  // ==========================================================
  // Supply turned on but power good missing for the selected
  // time drops the request again.
  crowbar_timer #(
    .CNT_W(CNT_W),
    .T0(T0_CYC),
    .T1(T1_CYC),
    .T2(T2_CYC),
    .T3(T3_CYC),
    .GAP(GAP_CYC)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .start(on_reg && !on_prev_reg),
    .stop(power_good || !on_reg),
    .sel(crowbar_reg),
    .expired(expired)
  );

  // ==========================================================
  // Output pins
  // ==========================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      supply_on_output <= 1'b1;
      led_out <= 2'b00;
      crowbar_trip <= 1'b0;
    end else begin
      supply_on_output <= polarity_reg ? on_reg : !on_reg;
      led_out <= led_lit ^ {2{led_pol_reg}};
      crowbar_trip <= expired;
    end
  end

  // ==========================================================
  // Assertion helpers
  // ==========================================================
  // Saturates so a long on-time never wraps into a short one
  logic [CNT_W-1:0] trip_cnt_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trip_cnt_reg <= '0;
    end else if (on_reg && !on_prev_reg) begin
      trip_cnt_reg <= '0;
    end else if (trip_cnt_reg != '1) begin
      trip_cnt_reg <= trip_cnt_reg + 1'b1;
    end
  end

  // Earliest legal trip: one gap past the band below
  function automatic int band_floor(input logic [1:0] s);
    unique case (s)
      2'b00: band_floor = T0_CYC;
      2'b01: band_floor = T0_CYC + GAP_CYC;
      2'b10: band_floor = T1_CYC + GAP_CYC;
      2'b11: band_floor = T2_CYC + GAP_CYC;
    endcase
  endfunction

  // ==========================================================
  // Assertions
  // ==========================================================
  rsp_pulse_a: assert property (
    @(posedge clk) disable iff (!nrst)
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("bus answer held too long");
  bad_index_a: assert property (
    @(posedge clk) disable iff (!nrst)
    apb_req.psel && !apb_req.penable && apb_req.paddr[11:2] != `CFG_INDEX
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000)
    else $error("unmapped index not refused");
  rd_data_a: assert property (
    @(posedge clk) disable iff (!nrst)
    apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
    apb_req.paddr[11:2] == `CFG_INDEX
    |=> apb_rsp.prdata == {24'h000000, $past(rdata)})
    else $error("read data not the register byte");
  battery_keep_a: assert property (
    @(posedge clk) disable iff (!nrst)
    standby_powerup && !wr_en
    |=> $stable(crowbar_reg) && $stable(resume_reg))
    else $error("battery-backed field lost on standby reset");

  rd_off_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    apb_rsp.pready |-> !apb_rsp.prdata[1])
    else $error("shut-off bit read back as one");

  led_level_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 led_out == ($past(led_lit) ^ {2{$past(led_pol_reg)}}))
    else $error("LED output polarity wrong");
  mode_clear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    standby_powerup |=> !acpi_mode_reg && !led_pol_reg)
    else $error("standby reset fields not cleared");

  snapshot_a: assert property (
    @(posedge clk) disable iff (!nrst)
    standby_fail |=> last_state_reg == $past(on_reg))
    else $error("failure snapshot missed");
  acpi_hide_a: assert property (
    @(posedge clk) disable iff (!nrst)
    acpi_mode_reg && !standby_powerup && apb_req.psel && !apb_req.penable
    |=> !apb_rsp.prdata[6])
    else $error("last state visible in ACPI mode");
  last_ro_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_en && !standby_fail |=> $stable(last_state_reg))
    else $error("last state changed by a write");

  pin_polarity_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ##2 supply_on_output == ($past(polarity_reg) ~^ $past(on_reg)))
    else $error("supply pin level wrong");
  strap_latch_a: assert property (
    @(posedge clk) disable iff (!nrst)
    standby_powerup |=> polarity_reg == $past(supply_polarity_strap))
    else $error("strap not latched on standby power-up");
  polarity_ro_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_en && !standby_powerup && strap_done_reg |=> $stable(polarity_reg))
    else $error("polarity changed by a write");

  crowbar_wr_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_en |=> crowbar_reg == $past(wdata_raw[4:3]))
    else $error("crowbar field not written");
  trip_a: assert property (
    @(posedge clk) disable iff (!nrst)
    expired && !standby_powerup |=> !on_reg && crowbar_trip)
    else $error("crowbar trip did not drop supply");
  trip_once_a: assert property (
    @(posedge clk) disable iff (!nrst)
    crowbar_trip |=> !crowbar_trip)
    else $error("crowbar trip longer than one cycle");
  crowbar_floor_a: assert property (
    @(posedge clk) disable iff (!nrst)
    expired |-> int'(trip_cnt_reg) >= band_floor(crowbar_reg))
    else $error("crowbar trip inside the band below");

  resume_a: assert property (
    @(posedge clk) disable iff (!nrst)
    standby_powerup && resume_reg
    |=> on_reg == $past(last_state_reg))
    else $error("last state not restored");
  follow_s3_a: assert property (
    @(posedge clk) disable iff (!nrst)
    s3_change && !standby_powerup && !shutoff && !expired
    |=> on_reg == $past(sleep_s3_input) [*1])
    else $error("supply did not follow S3");
  follow_pwrup_a: assert property (
    @(posedge clk) disable iff (!nrst)
    standby_powerup && !resume_reg
    |=> on_reg == $past(sleep_s3_input))
    else $error("power-up did not follow S3");

  shutoff_a: assert property (
    @(posedge clk) disable iff (!nrst)
    shutoff && !standby_powerup
    |=> !on_reg ##1 supply_on_output != polarity_reg)
    else $error("legacy shut-off ignored");
  acpi_keep_a: assert property (
    @(posedge clk) disable iff (!nrst)
    wr_en && wdata.supply_off && acpi_mode_reg && !standby_powerup &&
    !s3_change && !expired |=> $stable(on_reg))
    else $error("ACPI mode shut-off acted");

  resume_c: cover property (@(posedge clk) disable iff (!nrst)
    standby_powerup && resume_reg && last_state_reg);
  follow_c: cover property (@(posedge clk) disable iff (!nrst)
    standby_powerup && !resume_reg);
  shutoff_c: cover property (@(posedge clk) disable iff (!nrst)
    shutoff && on_reg);
  acpi_c: cover property (@(posedge clk) disable iff (!nrst)
    wr_en && wdata.supply_off && acpi_mode_reg);
  trip_c: cover property (@(posedge clk) disable iff (!nrst)
    expired);

endmodule // power_supply_control

// *** core/power_ctrl_params.svh ***
`ifndef POWER_CTRL_PARAMS_SVH
`define POWER_CTRL_PARAMS_SVH
// Register index; byte address is four times the index
`define CFG_INDEX 10'h02D
// Reset values (battery power-up)
`define LED_POL_RST 1'b0
`define LAST_STATE_RST 1'b0
`define POLARITY_RST 1'b0
`define CROWBAR_RST 2'b11
`define RESUME_RST 1'b0
`define ACPI_MODE_RST 1'b0
// Clock rate and crowbar times
`define CLK_KHZ 250000
`define CROWBAR_T0_MS 600
`define CROWBAR_T1_MS 1100
`define CROWBAR_T2_MS 1600
`define CROWBAR_T3_MS 2100
`define CROWBAR_GAP_MS 250
`endif

// *** core/power_ctrl_pkg.sv ***
package power_ctrl_pkg;
  typedef struct packed {
    logic led_pol;
    logic last_state;
    logic polarity;
    logic [1:0] crowbar;
    logic resume;
    logic supply_off;
    logic acpi_mode;
  } cfg_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;
endpackage

// *** core/apb_cfg_port.sv ***
`timescale 1ns/1ps
`include "power_ctrl_params.svh"
module apb_cfg_port import power_ctrl_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire apb_req_type req,
  input wire logic [7:0] rdata,
  output apb_rsp_type rsp,
  output logic wr_en,
  output logic [7:0] wdata
);
  logic hit;
  logic setup;
  assign hit = (req.paddr[11:2] == `CFG_INDEX);
  assign setup = req.psel && !req.penable;
  // Write commits only at the access edge that samples pready
  assign wr_en = req.psel && req.penable && rsp.pready && req.pwrite
    && hit;
  assign wdata = req.pwdata[7:0];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else if (setup) begin
      rsp.pready <= 1'b1;
      rsp.pslverr <= !hit;
      rsp.prdata <= (hit && !req.pwrite) ? {24'h000000, rdata} :
        32'h00000000;
    end else begin
      rsp <= '0;
    end
  end
endmodule // apb_cfg_port

// *** core/crowbar_timer.sv ***
`timescale 1ns/1ps
module crowbar_timer #(
  parameter int CNT_W = 30,
  parameter int T0 = 1,
  parameter int T1 = 2,
  parameter int T2 = 3,
  parameter int T3 = 4,
  parameter int GAP = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic stop,
  input wire logic [1:0] sel,
  output logic expired
);
  logic [CNT_W-1:0] cnt_reg;
  logic armed_reg;
  if (T0 < 1 || GAP < 1 || T1 - T0 < GAP || T2 - T1 < GAP ||
      T3 - T2 < GAP || T3 >= 2**CNT_W) begin : g_bad
    $error("crowbar_timer: counts not increasing by gap or too wide");
  end
  function automatic logic [CNT_W-1:0] limit(input logic [1:0] s);
    unique case (s)
      2'b00: limit = CNT_W'(T0 - 1);
      2'b01: limit = CNT_W'(T1 - 1);
      2'b10: limit = CNT_W'(T2 - 1);
      2'b11: limit = CNT_W'(T3 - 1);
    endcase
  endfunction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      armed_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        cnt_reg <= '0;
        armed_reg <= 1'b1;
      end else if (stop) begin
        armed_reg <= 1'b0;
      end else if (armed_reg) begin
        if (cnt_reg >= limit(sel)) begin
          armed_reg <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule // crowbar_timer

// *** test/supply_model.sv ***
`timescale 1ns/1ps
// ============================================================
// Supply model: reports good a few cycles after switch-on
module supply_model #(
  parameter logic STRAP = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supply_on_output,
  input wire logic slow,
  output logic power_good,
  output logic supply_polarity_strap
);
  logic [1:0] cnt_reg;
  assign supply_polarity_strap = STRAP;
  // Slow mode never reports good, so the crowbar must trip
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 2'h0;
      power_good <= 1'b0;
    end else if (supply_on_output !== STRAP || slow) begin
      cnt_reg <= 2'h0;
      power_good <= 1'b0;
    end else if (cnt_reg != 2'h3) begin
      cnt_reg <= cnt_reg + 2'h1;
    end else begin
      power_good <= 1'b1;
    end
  end
endmodule // supply_model

// *** test/power_supply_control_tb_top.sv ***
`timescale 1ns/1ps
module power_supply_control_tb_top import power_ctrl_pkg::*;;
  logic clk, nrst, s3, slow, strap, pgood, sb_up, sb_fail, pin, trip;
  logic [1:0] lit, led;
  apb_req_type req;
  apb_rsp_type rsp;
  int n_errors, compares, cyc;
  logic [7:0] q;
  logic e;
  power_supply_control #(.T0_CYC(10), .T1_CYC(20), .T2_CYC(30),
    .T3_CYC(40), .GAP_CYC(5)) dut (.clk(clk), .nrst(nrst),
    .apb_req(req), .apb_rsp(rsp), .sleep_s3_input(s3),
    .supply_polarity_strap(strap), .standby_powerup(sb_up),
    .standby_fail(sb_fail), .power_good(pgood), .led_lit(lit),
    .supply_on_output(pin), .led_out(led), .crowbar_trip(trip));
  supply_model model (.clk(clk), .nrst(nrst), .supply_on_output(pin),
    .slow(slow), .power_good(pgood), .supply_polarity_strap(strap));
  // ============================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  // ============================================================
  // Helpers
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    q = rsp.prdata[7:0];
    e = rsp.pslverr;
    req <= '0;
  endtask
  // Bounded wait for the supply pin; strap high means active high
  task automatic wait_pin(input logic v, input int lim);
    int n;
    n = 0;
    while (pin !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(pin, v, "supply pin");
  endtask
  task automatic pulse(input logic up);
    @(posedge clk);
    if (up) sb_up <= 1'b1;
    else sb_fail <= 1'b1;
    @(posedge clk);
    sb_up <= 1'b0;
    sb_fail <= 1'b0;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_regs();
    apb(0, 12'h0B4, 8'h00);
    chk({e, q}, 9'h038, "reset value");
    apb(0, 12'h0B8, 8'h00);
    chk({e, q}, 9'h100, "unmapped read");
  endtask
  task automatic t_follow_shutoff();
    s3 <= 1'b1;
    wait_pin(1'b1, 6);
    apb(1, 12'h0B4, 8'h1A);
    wait_pin(1'b0, 4);
    apb(0, 12'h0B4, 8'h00);
    chk(q, 8'h38, "shut-off reads zero");
  endtask
  task automatic t_acpi();
    apb(1, 12'h0B4, 8'h19);
    s3 <= 1'b0;
    repeat (3) @(posedge clk);
    s3 <= 1'b1;
    wait_pin(1'b1, 6);
    apb(1, 12'h0B4, 8'h1B);
    repeat (4) @(posedge clk);
    chk(pin, 1'b1, "shut-off ignored");
    apb(0, 12'h0B4, 8'h00);
    chk(q, 8'h39, "mode readback");
  endtask
  task automatic t_resume();
    apb(1, 12'h0B4, 8'h1C);
    pulse(1'b0);
    apb(0, 12'h0B4, 8'h00);
    chk(q, 8'h7C, "last state");
    s3 <= 1'b0;
    wait_pin(1'b0, 6);
    pulse(1'b1);
    wait_pin(1'b1, 4);
    apb(1, 12'h0B4, 8'h18);
    s3 <= 1'b1;
    repeat (2) @(posedge clk);
    s3 <= 1'b0;
    wait_pin(1'b0, 6);
    pulse(1'b1);
    repeat (3) @(posedge clk);
    chk(pin, 1'b0, "power-up follows S3");
  endtask
  task automatic t_led();
    apb(1, 12'h0B4, 8'h98);
    lit <= 2'b01;
    repeat (2) @(posedge clk);
    chk(led, 2'b10, "led inverted");
    apb(0, 12'h0B4, 8'h00);
    chk(q, 8'hF8, "led readback");
    apb(1, 12'h0B4, 8'h99);
    apb(0, 12'h0B4, 8'h00);
    chk(q, 8'hB9, "last state hidden");
  endtask
  // Every timeout code; trip must land before the next band opens
  task automatic t_crowbar();
    int lim[4];
    int n;
    lim = '{10, 20, 30, 40};
    slow <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(1, 12'h0B4, {3'h0, 2'(k), 3'h0});
      s3 <= 1'b1;
      n = 0;
      while (trip !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk(n >= lim[k] && n <= lim[k] + 5, 1'b1, "crowbar time");
      wait_pin(1'b0, 3);
      s3 <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // ============================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    s3 = 1'b0;
    slow = 1'b0;
    sb_up = 1'b0;
    sb_fail = 1'b0;
    lit = 2'b00;
    req = '0;
    n_errors = 0;
    compares = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_follow_shutoff();
    t_acpi();
    t_resume();
    t_led();
    t_crowbar();
    test_done();
  end
endmodule // power_supply_control_tb_top
